// ==== rtl/dfts_supervisor.sv ====
/*
 * Drive fault trip supervisor: cuts the power output on any trip,
 * shows the fault code, keeps a five-deep history and raises an
 * interrupt. Registers sit on an APB slave.
 * Assumes sense inputs synchronous to pclk and debounced
 * reset key and terminal levels.
 */
// Notes on behaviour
// [RQ1] Any fault cuts output and shows its code.
// [RQ2] Last five trips kept with status at trip.
// [RQ3] Current over 200 % trips primary overcurrent.
// [RQ4] Ground current over threshold trips ground fault.
// [RQ5] Bus over rating trips overvoltage.
// [RQ6] 180 % past limit time trips overload.
// [RQ7] Open fuse reports fault, output off.
// [RQ8] Hot heat sink trips.
// [RQ9] 150 % load for one minute trips thermal model.
// [RQ10] Closed NO contact trips.
// [RQ11] Opened NC contact trips.
// [RQ12] Bus under level trips undervoltage.
// [RQ13] Shoot-through or short trips secondary fault.
// [RQ14] Any open phase trips phase loss.
// [RQ15] Cut-off stops output; release resumes alone.
// [RQ16] Option failure raises option fault.
// [RQ17] Watchdog, memory or converter error trips hardware fault.
// [RQ18] Lost keypad shows communication error.
// [RQ19] Latch clears by key, terminal or power-up only.
`timescale 1ns/1ps

module dfts_supervisor #(
    parameter int unsigned MS_CYCLES = dfts_pkg::MS_CYCLES
) (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Protection inputs
    input  dfts_pkg::dfts_sense_type   sense,
    input  wire logic                  emergency_cutoff_input,
    input  wire logic                  reset_key,
    input  wire logic                  reset_terminal,
    input  wire logic [15:0]           op_status,
    // Drive side outputs
    output logic                       power_enable,
    output dfts_pkg::dfts_code_type    fault_status_display_param,
    output logic                       irq
);
    import dfts_pkg::*;

    // Fault condition vector and decode results
    dfts_code_type  next_code;
    logic           any_fault;
    logic           latched;
    dfts_code_type  latched_code;
    logic           trip_now;
    logic           clear_req;
    logic           overload_expired;
    logic           thermal_expired;

    // Registers
    logic [15:0]    olt_limit;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [2:0]     hist_count;
    logic           cutoff_q;

    // Bus decode
    logic           setup_ph;
    logic           access_ph;
    logic           wr_done;
    logic [2:0]     hist_index;
    dfts_entry_type hist_rd;
    logic [31:0]    next_rdata;
    logic           next_err;
    logic [IRQ_W-1:0] irq_event;

    // Address check, used for both read data and error reply
    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = (a == OFS_STATUS) || (a == OFS_OLT_LIMIT) ||
                      (a == OFS_IRQ_STAT) || (a == OFS_IRQ_MASK) ||
                      (a == OFS_HIST_CNT) ||
                      ((a >= OFS_HIST_BASE) && (a <= OFS_HIST_LAST) &&
                       (a[1:0] == 2'b00));
    endfunction

    // Priority pick of the most severe active condition
    function automatic dfts_code_type pick_fault(
        input dfts_sense_type s,
        input logic           olt_exp,
        input logic           eth_exp
    );
        pick_fault = FC_NONE;
        // [RQ18] keypad link loss
        if (s.keypad_lost)               pick_fault = FC_KEYPAD_COMM;
        // [RQ17] control diagnostics
        if (s.wdog_err || s.eep_err || s.adc_offset_err)
                                         pick_fault = FC_CONTROL_HW;
        // [RQ16] option failure
        if (s.option_fail)               pick_fault = FC_OPTION_MODULE;
        // [RQ11] NC contact opens
        if (!s.ext_nc_closed)            pick_fault = FC_EXT_FAULT_NC_CONTACT;
        // [RQ10] NO contact closes
        if (s.ext_no_closed)             pick_fault = FC_EXT_FAULT_NO_CONTACT;
        // [RQ14] any phase open
        if (|s.phase_open)               pick_fault = FC_OUTPUT_PHASE_LOSS;
        // [RQ9] thermal model expiry
        if (eth_exp)                     pick_fault = FC_MOTOR_THERMAL_MODEL;
        // [RQ6] overload time expiry
        if (olt_exp)                     pick_fault = FC_OVERLOAD_LIMIT;
        // [RQ8] heat sink hot
        if (s.heatsink_hot)              pick_fault = FC_HEATSINK_OVERTEMP;
        // [RQ12] bus under level
        if (s.bus_under_level)           pick_fault = FC_BUS_UNDERVOLTAGE;
        // [RQ5] bus over rating
        if (s.bus_over_rated)            pick_fault = FC_BUS_OVERVOLTAGE;
        // [RQ7] fuse opened
        if (s.fuse_open)                 pick_fault = FC_FUSE_OPEN;
        // [RQ4] ground over threshold
        if (s.ground_over_limit)         pick_fault = FC_GROUND_FAULT;
        // [RQ3] current over 200 %
        if (s.cur_over_200)              pick_fault = FC_OVERCURRENT_PRIMARY;
        // [RQ13] shoot-through or short
        if (s.switch_short)              pick_fault = FC_SWITCH_SHORT;
    endfunction

    // [RQ6] overload timer, restarts
    dfts_sustain_timer #(
        .TICK_CYCLES (MS_CYCLES)
    ) u_overload_timer (
        .pclk     (pclk),
        .presetn  (presetn),
        .active   (sense.cur_over_180),
        .leak     (1'b0),
        .limit_ms ({16'h0, olt_limit}),
        .expired  (overload_expired)
    );

    // [RQ9] thermal model, cools slowly
    dfts_sustain_timer #(
        .TICK_CYCLES (MS_CYCLES)
    ) u_thermal_model (
        .pclk     (pclk),
        .presetn  (presetn),
        .active   (sense.motor_over_150),
        .leak     (1'b1),
        .limit_ms (32'(THERMAL_MS)),
        .expired  (thermal_expired)
    );

    // Combined decode
    assign next_code = pick_fault(sense, overload_expired, thermal_expired);
    assign any_fault = (next_code != FC_NONE);
    // [RQ19] only key, terminal or power-up
    assign clear_req = reset_key || reset_terminal;
    // A new trip is taken only when nothing is latched yet or a clear is requested
    assign trip_now  = any_fault && (!latched || clear_req);

    // [RQ19] latch, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latched      <= 1'b0;
            latched_code <= FC_NONE;
        end else if (trip_now) begin
            latched      <= 1'b1;
            latched_code <= next_code;
        end else if (clear_req) begin
            latched      <= 1'b0;
            latched_code <= FC_NONE;
        end
    end

    // [RQ15] cut-off tracked, never latched
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cutoff_q <= 1'b0;
        end else begin
            cutoff_q <= emergency_cutoff_input;
        end
    end

    // [RQ1] output off on trip or cut-off
    // The raw fault also gates here so the output drops on the edge that sets the latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_enable <= 1'b0;
        end else begin
            power_enable <= !(latched && !clear_req) && !any_fault &&
                            !emergency_cutoff_input;
        end
    end

    // [RQ1] code shown on the display
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_status_display_param <= FC_NONE;
        end else if (trip_now) begin
            fault_status_display_param <= next_code;
        end else if (latched && !clear_req) begin
            fault_status_display_param <= latched_code;
        end else if (emergency_cutoff_input) begin
            fault_status_display_param <= FC_EMERGENCY_CUTOFF;
        end else begin
            fault_status_display_param <= FC_NONE;
        end
    end

    // [RQ2] record code with status
    dfts_history_mem u_history (
        .pclk       (pclk),
        .presetn    (presetn),
        .push       (trip_now),
        .push_entry ({next_code, op_status}),
        .rd_index   (hist_index),
        .rd_entry   (hist_rd)
    );

    // [RQ2] count of valid entries
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist_count <= 3'h0;
        end else if (trip_now && hist_count < 3'(HIST_DEPTH)) begin
            hist_count <= hist_count + 3'h1;
        end
    end

    // APB phases; every access takes two access cycles so history
    // reads have time to come out of the registered memory port
    assign setup_ph   = psel && !penable;
    assign access_ph  = psel && penable;
    assign wr_done    = access_ph && pready && pwrite &&
                        addr_mapped(paddr);
    assign hist_index = 3'((paddr - OFS_HIST_BASE) >> 2);

    // Wait state then ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= access_ph && !pready;
        end
    end

    // Read mux, unmapped reads as zero
    always_comb begin
        next_rdata = 32'h0;
        next_err   = !addr_mapped(paddr);
        if (paddr == OFS_STATUS) begin
            next_rdata[ST_CODE_LSB +: CODE_W] = fault_status_display_param;
            next_rdata[ST_OUT_EN]             = power_enable;
            next_rdata[ST_CUTOFF]             = cutoff_q;
            next_rdata[ST_LATCHED]            = latched;
        end else if (paddr == OFS_OLT_LIMIT) begin
            next_rdata[15:0] = olt_limit;
        end else if (paddr == OFS_IRQ_STAT) begin
            next_rdata[IRQ_W-1:0] = irq_stat;
        end else if (paddr == OFS_IRQ_MASK) begin
            next_rdata[IRQ_W-1:0] = irq_mask;
        end else if (paddr == OFS_HIST_CNT) begin
            next_rdata[2:0] = hist_count;
        end else if (addr_mapped(paddr)) begin
            next_rdata[ENTRY_W-1:0] = hist_rd;
        end
    end

    // Data and error captured with the ready edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else if (access_ph && !pready) begin
            prdata  <= pwrite ? 32'h0 : next_rdata;
            pslverr <= next_err;
        end else begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end
    end

    // [RQ6] limit time in milliseconds
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            olt_limit <= RST_OLT_LIMIT;
        end else if (wr_done && paddr == OFS_OLT_LIMIT) begin
            olt_limit <= pwdata[15:0];
        end
    end

    // Interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= RST_IRQ_MASK;
        end else if (wr_done && paddr == OFS_IRQ_MASK) begin
            irq_mask <= pwdata[IRQ_W-1:0];
        end
    end

    // Events: trip, cut-off rising, latched fault cleared
    always_comb begin
        irq_event              = '0;
        irq_event[IRQ_TRIP]    = trip_now;
        irq_event[IRQ_CUTOFF]  = emergency_cutoff_input && !cutoff_q;
        irq_event[IRQ_CLEARED] = latched && clear_req && !trip_now;
    end

    // Sticky status, write one to clear; a new event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
        end else if (wr_done && paddr == OFS_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~pwdata[IRQ_W-1:0]) | irq_event;
        end else begin
            irq_stat <= irq_stat | irq_event;
        end
    end

    // Level interrupt, one cycle behind the status bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end

endmodule

// ==== rtl/dfts_pkg.sv ====
/*
 * Trip supervisor constants: offsets, fields, reset values,
 * timing counts, fault codes and the sense bundle.
 * Assumes a 25 MHz clock and sense levels synchronous to it.
 */
package dfts_pkg;

    // Clock and time base
    localparam int unsigned CLK_HZ        = 25000000;
    localparam int unsigned MS_PER_S      = 1000;
    localparam int unsigned MS_CYCLES     = CLK_HZ / MS_PER_S;
    // Motor thermal capacity: 150 % load sustained for 1 min
    localparam int unsigned THERMAL_MIN   = 1;
    localparam int unsigned THERMAL_MS    = THERMAL_MIN * 60 * MS_PER_S;

    // History depth and entry layout
    localparam int unsigned HIST_DEPTH    = 5;
    localparam int unsigned STATUS_W      = 16;
    localparam int unsigned CODE_W        = 5;
    localparam int unsigned ENTRY_W       = CODE_W + STATUS_W;

    // Register byte offsets
    localparam logic [11:0] OFS_STATUS    = 12'h000;
    localparam logic [11:0] OFS_OLT_LIMIT = 12'h004;
    localparam logic [11:0] OFS_IRQ_STAT  = 12'h008;
    localparam logic [11:0] OFS_IRQ_MASK  = 12'h00c;
    localparam logic [11:0] OFS_HIST_CNT  = 12'h010;
    localparam logic [11:0] OFS_HIST_BASE = 12'h020;
    localparam logic [11:0] OFS_HIST_LAST = 12'h030;

    // Status register fields
    localparam int unsigned ST_CODE_LSB   = 0;
    localparam int unsigned ST_OUT_EN     = 8;
    localparam int unsigned ST_CUTOFF     = 9;
    localparam int unsigned ST_LATCHED    = 10;

    // Interrupt bits (status and mask share the layout)
    localparam int unsigned IRQ_W         = 3;
    localparam int unsigned IRQ_TRIP      = 0;
    localparam int unsigned IRQ_CUTOFF    = 1;
    localparam int unsigned IRQ_CLEARED   = 2;

    // Reset values
    localparam logic [15:0] RST_OLT_LIMIT = 16'h0064;
    localparam logic [2:0]  RST_IRQ_MASK  = 3'h0;

    // Fault codes, in trip priority order after none
    typedef enum logic [CODE_W-1:0] {
        FC_NONE,
        FC_SWITCH_SHORT,
        FC_OVERCURRENT_PRIMARY,
        FC_GROUND_FAULT,
        FC_FUSE_OPEN,
        FC_BUS_OVERVOLTAGE,
        FC_BUS_UNDERVOLTAGE,
        FC_HEATSINK_OVERTEMP,
        FC_OVERLOAD_LIMIT,
        FC_MOTOR_THERMAL_MODEL,
        FC_OUTPUT_PHASE_LOSS,
        FC_EXT_FAULT_NO_CONTACT,
        FC_EXT_FAULT_NC_CONTACT,
        FC_OPTION_MODULE,
        FC_CONTROL_HW,
        FC_KEYPAD_COMM,
        FC_EMERGENCY_CUTOFF
    } dfts_code_type;

    // Protection comparator and contact levels, high = condition true
    typedef struct packed {
        logic       cur_over_200;
        logic       cur_over_180;
        logic       ground_over_limit;
        logic       bus_over_rated;
        logic       bus_under_level;
        logic       fuse_open;
        logic       heatsink_hot;
        logic       motor_over_150;
        logic       ext_no_closed;
        logic       ext_nc_closed;
        logic       switch_short;
        logic [2:0] phase_open;
        logic       option_fail;
        logic       wdog_err;
        logic       eep_err;
        logic       adc_offset_err;
        logic       keypad_lost;
    } dfts_sense_type;

    // One history entry
    typedef struct packed {
        dfts_code_type         code;
        logic [STATUS_W-1:0]   status;
    } dfts_entry_type;

endpackage

// ==== rtl/dfts_history_mem.sv ====
/*
 * Five-entry fault history: a push shifts every entry one place
 * older and writes the newest at index 0. Read data come from a
 * register one clock after the index is presented.
 * Assumes at most one push per clock.
 */
`timescale 1ns/1ps

module dfts_history_mem
    import dfts_pkg::*;
(
    // Clock and reset
    input  wire logic           pclk,
    input  wire logic           presetn,
    // Write side
    input  wire logic           push,
    input  dfts_pkg::dfts_entry_type push_entry,
    // Read side
    input  wire logic [2:0]     rd_index,
    output dfts_pkg::dfts_entry_type rd_entry
);
    import dfts_pkg::*;

    dfts_entry_type entry [HIST_DEPTH];

    // Shift chain, newest first
    genvar g;
    generate
        for (g = 0; g < HIST_DEPTH; g++) begin : g_slot
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    entry[g] <= '0;
                end else if (push) begin
                    if (g == 0) begin
                        entry[g] <= push_entry;
                    end else begin
                        entry[g] <= entry[g-1];
                    end
                end
            end
        end
    endgenerate

    // Registered read; out of range reads as an empty entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_entry <= '0;
        end else if (rd_index < 3'(HIST_DEPTH)) begin
            rd_entry <= entry[rd_index];
        end else begin
            rd_entry <= '0;
        end
    end

endmodule

// ==== rtl/dfts_sustain_timer.sv ====
/*
 * Millisecond accumulator that expires once its condition has held
 * for the limit; without leak a drop restarts it, with leak it
 * bleeds down one step per millisecond.
 * Assumes the limit is stable while counting.
 */
`timescale 1ns/1ps

module dfts_sustain_timer #(
    parameter int unsigned TICK_CYCLES = dfts_pkg::MS_CYCLES
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Condition and setup
    input  wire logic        active,
    input  wire logic        leak,
    input  wire logic [31:0] limit_ms,
    // Result
    output logic             expired
);
    import dfts_pkg::*;

    logic [31:0] pre;
    logic [31:0] acc;
    logic        tick;

    // Millisecond prescaler, free running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre <= '0;
        end else if (pre >= 32'(TICK_CYCLES - 1)) begin
            pre <= '0;
        end else begin
            pre <= pre + 32'h1;
        end
    end
    assign tick = (pre >= 32'(TICK_CYCLES - 1));

    // Accumulate while active, restart or bleed otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= '0;
        end else if (active) begin
            if (tick && (acc < limit_ms || acc == 32'h0)) begin
                acc <= acc + 32'h1;
            end
        end else if (!leak) begin
            acc <= '0;
        end else if (tick && acc != 32'h0) begin
            acc <= acc - 32'h1;
        end
    end

    // Zero limit would trip at once, so it needs one full tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            expired <= 1'b0;
        end else begin
            expired <= active && (acc >= limit_ms) && (acc != 32'h0);
        end
    end

endmodule

// ==== tb/dfts_chk.sv ====
/* Port-level checker for the trip supervisor.
   Assumes it is bound to dfts_supervisor, one clock domain. */
`timescale 1ns/1ps

module dfts_chk
    import dfts_pkg::*;
(
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // APB answer
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic [31:0]        prdata,
    input  wire logic               pready,
    input  wire logic               pslverr,
    // Drive side
    input  dfts_pkg::dfts_sense_type sense,
    input  wire logic               emergency_cutoff_input,
    input  wire logic               reset_key,
    input  wire logic               reset_terminal,
    input  wire logic               power_enable,
    input  dfts_pkg::dfts_code_type fault_status_display_param
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic          any_f;
    logic          quiet;
    dfts_code_type code;
    // NC contact inverted; timed conditions left out on purpose
    assign any_f = |((sense ^ 19'h00200) & 19'h5f7ff);
    assign quiet = !any_f && !emergency_cutoff_input
                   && !sense.cur_over_180 && !sense.motor_over_150;
    assign code = fault_status_display_param;

    a_trip_cuts_out: assert property (any_f |=> !power_enable)
        else $error("output left on with a fault present");
    a_short_first: assert property (code == FC_NONE
        && !emergency_cutoff_input && sense.switch_short
        |=> code == FC_SWITCH_SHORT) else $error("short code wrong");
    a_oc_code: assert property (code == FC_NONE
        && !emergency_cutoff_input && sense.cur_over_200
        && !sense.switch_short |=> code == FC_OVERCURRENT_PRIMARY)
        else $error("overcurrent code wrong");
    a_cutoff_off: assert property (emergency_cutoff_input
        |=> !power_enable) else $error("cut-off ignored");
    a_cutoff_back: assert property (code == FC_EMERGENCY_CUTOFF
        && quiet |=> power_enable) else $error("no resume after cut-off");
    a_latch_holds: assert property (code != FC_NONE
        && code != FC_EMERGENCY_CUTOFF && !reset_key && !reset_terminal
        |=> $stable(code) && !power_enable) else $error("latch lost");
    a_clear_frees: assert property ((reset_key || reset_terminal)
        && quiet |=> code == FC_NONE && power_enable)
        else $error("clear request ignored");
    a_ready_timing: assert property (psel && !penable
        |=> !pready ##1 pready) else $error("ready not in second cycle");
    a_err_in_access: assert property ((pslverr || pready)
        |-> psel && penable) else $error("answer outside access");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside ready cycle");
endmodule

bind dfts_supervisor dfts_chk dfts_chk_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense(sense),
    .emergency_cutoff_input(emergency_cutoff_input),
    .reset_key(reset_key), .reset_terminal(reset_terminal),
    .power_enable(power_enable),
    .fault_status_display_param(fault_status_display_param)
);

// ==== tb/dfts_plant.sv ====
/* Power stage sensors, contacts and keypad as the supervisor sees them.
   Assumes the bench injects conditions, high = condition present. */
`timescale 1ns/1ps

module dfts_plant
    import dfts_pkg::*;
(
    // Injected conditions
    input  dfts_pkg::dfts_sense_type faults,
    // Levels at the supervisor
    output dfts_pkg::dfts_sense_type sense
);
    always_comb begin
        sense = faults;
        sense.ext_nc_closed = !faults.ext_nc_closed;
    end
endmodule

// ==== tb/dfts_supervisor_bench.sv ====
/* Self-checking bench for the trip supervisor.
   Assumes the plant model beside it and the checker bound in. */
`timescale 1ns/1ps

module dfts_supervisor_bench;
    import dfts_pkg::*;
    localparam int MSC = 4;
    logic           pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic           cut, rkey, rterm, power_enable, irq, e;
    logic [11:0]    paddr;
    logic [31:0]    pwdata, prdata, rnd, q;
    logic [15:0]    op_status;
    logic [18:0]    v;
    dfts_code_type  code;
    dfts_sense_type inj, sense;
    int             error_cnt, compares, cyc, cnt;
    logic [20:0]    hq[$];
    // Code per sense bit, 0 for the timed ones
    logic [4:0]     code_of [0:18] = '{15, 14, 14, 14, 13, 10, 10, 10, 1,
                                       12, 11, 0, 7, 4, 6, 5, 3, 0, 2};
    int             prio [0:16] = '{8, 18, 16, 13, 15, 14, 12, 7, 6, 5,
                                    10, 9, 4, 3, 2, 1, 0};

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] prio_code(input logic [18:0] m);
        foreach (prio[i]) if (m[prio[i]]) return 32'(code_of[prio[i]]);
        return 32'h0;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Setup, then access held until ready is seen
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask
    // Drop all conditions, pulse key or terminal
    task automatic clear(input logic t);
        inj   <= '0;
        tick(1);
        rkey  <= !t;
        rterm <= t;
        tick(1);
        rkey  <= 1'b0;
        rterm <= 1'b0;
        tick(2);
    endtask
    task automatic conclude;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    dfts_plant dfts_plant_inst (.faults (inj), .sense (sense));
    dfts_supervisor #(.MS_CYCLES (MSC)) dfts_supervisor_inst (
        .pclk (pclk), .presetn (presetn), .psel (psel),
        .penable (penable), .pwrite (pwrite), .paddr (paddr),
        .pwdata (pwdata), .prdata (prdata), .pready (pready),
        .pslverr (pslverr), .sense (sense),
        .emergency_cutoff_input (cut), .reset_key (rkey),
        .reset_terminal (rterm), .op_status (op_status),
        .power_enable (power_enable),
        .fault_status_display_param (code), .irq (irq));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Ceiling far above the planned run
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        rnd = 32'hfe32b088;
        {presetn, psel, penable, pwrite, cut, rkey, rterm} = '0;
        paddr = '0;
        pwdata = '0;
        op_status = '0;
        inj = '0;
        tick(20);
        presetn <= 1'b1;
        // Reset values, unmapped slot refused
        rd(OFS_OLT_LIMIT, 32'(RST_OLT_LIMIT));
        rd(OFS_IRQ_MASK, 32'(RST_IRQ_MASK));
        rd(12'h100, 32'h0);
        chk(32'(e), 32'h1);
        for (int b = 0; b < 19; b++) begin
            if (code_of[b] != 5'h0) begin
                rnd = lfsr(rnd);
                op_status <= rnd[15:0];
                inj <= dfts_sense_type'(19'h1 << b);
                tick(2);
                chk(32'(code), prio_code(19'h1 << b));
                chk(32'(power_enable), 32'h0);
                hq.push_front({code_of[b], rnd[15:0]});
                inj <= '0;
                tick(2);
                chk(32'(code), 32'(code_of[b]));
                clear(b[0]);
                chk(32'(power_enable), 32'h1);
            end
        end
        rd(OFS_HIST_CNT, 32'h5);
        for (int i = 0; i < 5; i++) begin
            rd(OFS_HIST_BASE + 12'(4 * i), 32'(hq[i]));
        end
        // Events stay hidden until unmasked
        chk(32'(irq), 32'h0);
        rd(OFS_IRQ_STAT, 32'h5);
        apb(1'b1, OFS_IRQ_MASK, 32'h7);
        tick(2);
        chk(32'(irq), 32'h1);
        apb(1'b1, OFS_IRQ_STAT, 32'h7);
        tick(2);
        chk(32'(irq), 32'h0);
        cut <= 1'b1;
        tick(2);
        chk(32'(code), 32'(FC_EMERGENCY_CUTOFF));
        cut <= 1'b0;
        tick(2);
        chk(32'(power_enable), 32'h1);
        chk(32'(irq), 32'h1);
        // Short run forgotten, long run trips
        apb(1'b1, OFS_OLT_LIMIT, 32'h3);
        inj.cur_over_180 <= 1'b1;
        tick(2 * MSC - 2);
        inj.cur_over_180 <= 1'b0;
        tick(2);
        chk(32'(code), 32'h0);
        inj.cur_over_180 <= 1'b1;
        for (cnt = 0; code !== FC_OVERLOAD_LIMIT && cnt < 8 * MSC; cnt++)
            tick(1);
        chk(32'(code), 32'(FC_OVERLOAD_LIMIT));
        chk(32'(cnt >= 2 * MSC), 32'h1);
        clear(1'b0);
        // Random mixes against the priority order
        for (int k = 0; k < 24; k++) begin
            rnd = lfsr(rnd);
            v = rnd[18:0] & 19'h5f7ff;
            inj <= dfts_sense_type'(v);
            op_status <= rnd[31:16];
            tick(2);
            chk(32'(code), prio_code(v));
            chk(32'(power_enable), 32'(v == 19'h0));
            clear(rnd[20]);
        end
        conclude();
    end
endmodule
